// *** hw/param_access_map.vh ***
`ifndef PARAM_ACCESS_MAP_VH
`define PARAM_ACCESS_MAP_VH
// Request operation codes.
`define OP_READ        8'h01
`define OP_WRITE       8'h02
// Response codes.
`define RSP_ERROR      8'h00
`define RSP_READ       8'h01
`define RSP_WRITE      8'h02
// Error marker and reason codes.
`define ERR_MARK       8'hff
`define ERR_BAD_OP     8'h01
`define ERR_BAD_INDEX  8'h02
`define ERR_BAD_TYPE   8'h03
`define ERR_NO_WRITE   8'h04
`define ERR_LIMITS     8'h05
`define ERR_BAD_ELEM   8'h06
`define ERR_NOT_ARRAY  8'h07
`define ERR_RESET_ONLY 8'h08
`define ERR_FIXED      8'h09
`define ERR_MODE       8'h0a
`define ERR_NO_BUS     8'h0b
`define ERR_OTHER      8'hfe
// Length field values.
`define LEN_VALUE      8'h04
`define LEN_ERROR      8'h04
`define LEN_NONE       8'h00
`define LEN_MAX        8'h1b
// Store answer timeout in clock cycles.
`define STORE_TIMEOUT  8'hff
`endif

// *** hw/request_decoder.v ***
`timescale 1ns/1ps
`default_nettype none
`include "param_access_map.vh"

// Splits a request record into fields and flags a bad operation code.
module request_decoder (
    // Request record, operation byte in the top bits.
    input  wire [63:0] record_in,
    // Decoded fields.
    output wire [7:0]  op_out,
    output wire [15:0] index_out,
    output wire [7:0]  element_out,
    output wire [31:0] value_out,
    output wire        op_bad_out
);
    // Field order is operation, index, element, value.
    assign op_out      = record_in[63:56];
    assign index_out   = record_in[55:40];
    assign element_out = record_in[39:32];
    assign value_out   = record_in[31:0];
    assign op_bad_out  = (op_out != `OP_READ) && (op_out != `OP_WRITE);
endmodule // request_decoder
`default_nettype wire

// *** hw/parameter_access_interpreter.v ***
// Summary of operation
// - One request input record port and one response output record port.
// - Request holds opcode, two-byte index, element byte, four-byte value.
// - Response holds code byte, two-byte index, length byte, value bytes.
// - Length counts value bytes, zero to twenty-seven, value carries that many.
// - Failed request answers value byte 0 all ones, reason in byte 3.
// - Reason codes one to eleven, 0xfe for any other failure.
// - Read values go least significant byte first.
`timescale 1ns/1ps
`default_nettype none
`include "param_access_map.vh"

// A strobe taken in idle starts one store access, or is refused locally
// for an unknown operation. The answer strobe follows two cycles after the
// store answers or after the wait timer runs out. busy_out covers the
// whole transfer and any strobe seen while it is high is dropped without
// an answer. That keeps pairing strict without a request queue, but the
// requester has to wait for each answer before sending the next record.

module parameter_access_interpreter (
    // Clock and reset.
    input  wire         clk_in,
    input  wire         reset_in,
    // Request record from the network, one-cycle valid strobe.
    input  wire [63:0]  param_request_input_in,
    input  wire         request_valid_in,
    // Response record to the network; value bytes are bytes 0..26.
    output reg  [7:0]   rsp_code_out,
    output reg  [15:0]  rsp_index_out,
    output reg  [7:0]   rsp_length_out,
    output reg  [215:0] param_response_output_out,
    output reg          response_valid_out,
    output reg          busy_out,
    // Parameter store access.
    output reg          store_req_out,
    output reg          store_write_out,
    output reg  [15:0]  store_index_out,
    output reg  [7:0]   store_element_out,
    output reg  [31:0]  store_wdata_out,
    input  wire         store_ack_in,
    input  wire         store_error_in,
    input  wire [7:0]   store_reason_in,
    input  wire [31:0]  store_rdata_in
);
    // -------------------------------------------------------------------
    // States.
    // -------------------------------------------------------------------
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_WAIT = 3'b010;
    localparam [2:0] S_DONE = 3'b100;

    // Idle waits for a strobe, wait keeps the store access open, and done
    // spends one cycle raising the answer strobe.
    reg [2:0] state_r;
    // Store wait cycles; eight bits hold the fixed limit without wrapping.
    reg [7:0] timer_r;

    // Decoded request fields.
    wire [7:0]  op_w;
    wire [15:0] index_w;
    wire [7:0]  element_w;
    wire [31:0] value_w;
    wire        op_bad_w;

    // -------------------------------------------------------------------
    // Request field split.
    // -------------------------------------------------------------------
    // The decoder is combinational and is only looked at in idle, in the
    // cycle a strobe is taken, so a record that changes afterwards cannot
    // disturb a transfer that is already in flight.
    request_decoder decoder (
        .record_in   (param_request_input_in),
        .op_out      (op_w),
        .index_out   (index_w),
        .element_out (element_w),
        .value_out   (value_w),
        .op_bad_out  (op_bad_w)
    );

    // -------------------------------------------------------------------
    // Answer builders.
    // -------------------------------------------------------------------
    // Code, length and value of an answer are set at one edge; the index is
    // set when the strobe is taken, so it leads the rest for a store access and shares their edge for a refused operation.
    // Builds the value field of an error answer; byte 0 at the low end.
    function [215:0] error_value;
        input [7:0] reason;
        begin
            error_value = {184'h0, reason, 16'h0000, `ERR_MARK};
        end
    endfunction

    // Maps store reasons outside the known set onto the catch-all code.
    // A zero reason from the store lands on the catch-all as well.
    function [7:0] clean_reason;
        input [7:0] reason;
        begin
            if (reason >= `ERR_BAD_OP && reason <= `ERR_NO_BUS) begin
                clean_reason = reason;
            end else begin
                clean_reason = `ERR_OTHER;
            end
        end
    endfunction

    // Places a read value in bytes 0..3, low byte first, so byte 1 weighs
    // 256 against byte 0; the spare bytes 4..26 stay zero.
    function [215:0] read_value;
        input [31:0] data;
        begin
            read_value = {184'h0, data};
        end
    endfunction

    // -------------------------------------------------------------------
    // Store wait timer.
    // -------------------------------------------------------------------
    // Runs only in the wait state and restarts from zero everywhere else,
    // so each access gets the full limit however long the last one took.
    // The compare against the limit lives in the sequencer.
    always @(posedge clk_in) begin
        if (reset_in) begin
            timer_r <= 8'h00;
        end else if (state_r != S_WAIT) begin
            timer_r <= 8'h00;
        end else begin
            timer_r <= timer_r + 8'h01;
        end
    end

    // -------------------------------------------------------------------
    // Sequencer.
    // -------------------------------------------------------------------
    // Requests arriving while busy are dropped, so the requester must wait
    // for the answer; this keeps strict one-for-one pairing without a queue.
    always @(posedge clk_in) begin
        if (reset_in) begin
            // Everything the network and the store see starts at zero.
            state_r                   <= S_IDLE;
            rsp_code_out              <= `RSP_ERROR;
            rsp_index_out             <= 16'h0000;
            rsp_length_out            <= `LEN_NONE;
            param_response_output_out <= 216'h0;
            response_valid_out        <= 1'b0;
            busy_out                  <= 1'b0;
            store_req_out             <= 1'b0;
            store_write_out           <= 1'b0;
            store_index_out           <= 16'h0000;
            store_element_out         <= 8'h00;
            store_wdata_out           <= 32'h0;
        end else begin
            response_valid_out <= 1'b0;
            store_req_out      <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    // The index is latched at once, so the echo never
                    // depends on the record standing after the strobe.
                    if (request_valid_in) begin
                        busy_out      <= 1'b1;
                        rsp_index_out <= index_w;
                        if (op_bad_w) begin
                            rsp_code_out   <= `RSP_ERROR;
                            rsp_length_out <= `LEN_ERROR;
                            param_response_output_out <=
                                error_value(`ERR_BAD_OP);
                            state_r <= S_DONE;
                        end else begin
                            store_req_out     <= 1'b1;
                            store_write_out   <= (op_w == `OP_WRITE);
                            store_index_out   <= index_w;
                            store_element_out <= element_w;
                            store_wdata_out   <= value_w;
                            state_r           <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    if (store_ack_in) begin
                        // Known store reasons pass through unchanged.
                        if (store_error_in) begin
                            rsp_code_out   <= `RSP_ERROR;
                            rsp_length_out <= `LEN_ERROR;
                            param_response_output_out <=
                                error_value(clean_reason(store_reason_in));
                        end else if (store_write_out) begin
                            rsp_code_out   <= `RSP_WRITE;
                            rsp_length_out <= `LEN_NONE;
                            param_response_output_out <= 216'h0;
                        end else begin
                            rsp_code_out   <= `RSP_READ;
                            rsp_length_out <= `LEN_VALUE;
                            param_response_output_out <=
                                read_value(store_rdata_in);
                        end
                        state_r <= S_DONE;
                    end else if (timer_r == `STORE_TIMEOUT) begin
                        // A silent store must not leave the requester hanging.
                        // The limit is fixed: an ack that turns up later is ignored in
                        // done or idle, but one that lands in a later wait answers that access.
                        rsp_code_out   <= `RSP_ERROR;
                        rsp_length_out <= `LEN_ERROR;
                        param_response_output_out <=
                            error_value(`ERR_OTHER);
                        state_r <= S_DONE;
                    end
                end
                S_DONE: begin
                    // Busy falls with the strobe, so a new request may be
                    // taken in the very cycle the answer is shown.
                    response_valid_out <= 1'b1;
                    busy_out           <= 1'b0;
                    state_r            <= S_IDLE;
                end
                // A corrupted state code falls back to idle, not a lockup.
                default: begin
                    state_r  <= S_IDLE;
                    busy_out <= 1'b0;
                end
            endcase
        end
    end
endmodule // parameter_access_interpreter
`default_nettype wire

// *** tb/param_access_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "param_access_map.vh"
// Watches the interpreter's response and store sides.
module param_access_assertions (
    input wire logic         clk_in, reset_in, request_valid_in, busy_out,
    input wire logic         response_valid_out, store_req_out,
    input wire logic         store_write_out, store_ack_in, store_error_in,
    input wire logic [63:0]  param_request_input_in,
    input wire logic [7:0]   rsp_code_out, rsp_length_out, store_element_out,
    input wire logic [15:0]  rsp_index_out, store_index_out,
    input wire logic [215:0] param_response_output_out,
    input wire logic [31:0]  store_rdata_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // Strobes seen while busy are dropped, so only idle ones count.
    wire logic        acc = request_valid_in && !busy_out;
    wire logic [15:0] idx = param_request_input_in[55:40];
    wire logic [7:0]  elm = param_request_input_in[39:32];
    wire logic [7:0]  b3 = param_response_output_out[31:24];
    wire logic        ok = param_request_input_in[63:56] inside {1, 2};
    wire logic        err = response_valid_out && rsp_code_out == `RSP_ERROR;
    wire logic        sok = busy_out && store_ack_in && !store_error_in;
    chk_valid_pulse: assert property (response_valid_out |=> !response_valid_out)
        else $error("response strobe too long");
    chk_index_echo: assert property (acc |=> busy_out && rsp_index_out == $past(idx))
        else $error("index not echoed");
    chk_answer_bound: assert property (acc |-> ##[2:260] response_valid_out)
        else $error("no response");
    chk_bad_op: assert property (acc && !ok |-> ##2 err && b3 == `ERR_BAD_OP)
        else $error("bad operation not refused");
    chk_store_fields: assert property (acc && ok |=> store_req_out &&
        store_index_out == $past(idx) && store_element_out == $past(elm))
        else $error("store fields wrong");
    chk_err_shape: assert property (err |-> rsp_length_out == `LEN_ERROR &&
        param_response_output_out[7:0] == `ERR_MARK) else $error("error shape");
    chk_reason_code: assert property (err |-> b3 inside {[1:11], 8'hfe})
        else $error("bad reason code");
    chk_len_max: assert property (response_valid_out |-> rsp_length_out <= 27)
        else $error("length too large");
    chk_read_lsb: assert property (sok && !store_write_out |-> ##2
        param_response_output_out[31:0] == $past(store_rdata_in, 2))
        else $error("read value order");
    chk_write_ack: assert property (sok && store_write_out |-> ##2
        rsp_code_out == `RSP_WRITE && rsp_length_out == 0) else $error("write ack");
endmodule // param_access_assertions
`default_nettype wire

// *** tb/param_store_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Parameter store; indexes 0xfxxx fail with reason taken from the low byte.
// Indexes 0xexxx are never answered, to drive the interpreter's timeout.
module param_store_model (
    input  wire logic        clk_in, reset_in, req_in, write_in,
    input  wire logic [15:0] index_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic [7:0]  delay_in,
    output logic             ack_out = 0, error_out = 0,
    output logic [7:0]       reason_out = 0,
    output logic [31:0]      rdata_out = 0
);
    logic [31:0] mem [int];
    int          cnt = -1;
    // Read data toggles outside an answer so stale values never match.
    always @(posedge clk_in) begin
        ack_out <= 0;
        error_out <= 0;
        rdata_out <= ~rdata_out;
        if (reset_in) cnt <= -1;
        else if (req_in) cnt <= index_in[15:12] == 4'he ? -1 : int'(delay_in);
        else if (cnt > 0) cnt <= cnt - 1;
        else if (cnt == 0) begin
            cnt <= -1;
            ack_out <= 1;
            error_out <= index_in[15:12] == 4'hf;
            reason_out <= index_in[7:0];
            if (index_in[15:12] == 4'hf) ;
            else if (write_in) mem[index_in] = wdata_in;
            else rdata_out <= mem.exists(index_in) ? mem[index_in] : 0;
        end
    end
endmodule // param_store_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "param_access_map.vh"
module tb;
    logic clk_in = 0, reset_in = 1, request_valid_in = 0;
    logic [63:0]  param_request_input_in = 0;
    logic [7:0]   rsp_code_out, rsp_length_out, store_element_out;
    logic [7:0]   store_reason_in, delay = 0;
    logic [15:0]  rsp_index_out, store_index_out;
    logic [215:0] param_response_output_out;
    logic response_valid_out, busy_out, store_req_out, store_write_out;
    logic store_ack_in, store_error_in;
    logic [31:0]  store_wdata_out, store_rdata_in;
    int errors = 0, tests_run = 0, cycles = 0, rsp_count = 0, seed;
    logic [31:0] ref_mem [int];
    parameter_access_interpreter parameter_access_interpreter_inst (
        .clk_in(clk_in), .reset_in(reset_in),
        .param_request_input_in(param_request_input_in),
        .request_valid_in(request_valid_in), .rsp_code_out(rsp_code_out),
        .rsp_index_out(rsp_index_out), .rsp_length_out(rsp_length_out),
        .param_response_output_out(param_response_output_out),
        .response_valid_out(response_valid_out), .busy_out(busy_out),
        .store_req_out(store_req_out), .store_write_out(store_write_out),
        .store_index_out(store_index_out),
        .store_element_out(store_element_out),
        .store_wdata_out(store_wdata_out), .store_ack_in(store_ack_in),
        .store_error_in(store_error_in), .store_reason_in(store_reason_in),
        .store_rdata_in(store_rdata_in));
    param_store_model param_store_model_inst (
        .clk_in(clk_in), .reset_in(reset_in),
        .req_in(store_req_out), .write_in(store_write_out),
        .index_in(store_index_out), .wdata_in(store_wdata_out),
        .delay_in(delay), .ack_out(store_ack_in), .error_out(store_error_in),
        .reason_out(store_reason_in), .rdata_out(store_rdata_in));
    initial forever #50 clk_in = ~clk_in;
    // A hang ends the run as a failure; answer strobes are counted here.
    always @(posedge clk_in) begin
        if (response_valid_out === 1'b1) rsp_count++;
        if (++cycles == 5000) begin
            errors++;
            conclude;
        end
    end
    task automatic check(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            errors++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    // One request; junk adds a strobe while busy, which must be dropped.
    task automatic xfer(input logic [7:0] op, input logic [15:0] idx,
                        input logic [31:0] val, input logic junk);
        logic [7:0] rsn;
        logic [215:0] v;
        int n;
        rsn = idx[7:0] inside {[1:11]} ? idx[7:0] : `ERR_OTHER;
        if (!(op inside {`OP_READ, `OP_WRITE})) rsn = `ERR_BAD_OP;
        else if (idx[15:12] == 4'he) rsn = `ERR_OTHER;
        else if (idx[15:12] != 4'hf) rsn = 0;
        delay = 8'($urandom_range(12, 0));
        @(posedge clk_in);
        request_valid_in <= 1;
        param_request_input_in <= {op, idx, 8'($urandom), val};
        @(posedge clk_in);
        request_valid_in <= junk;
        param_request_input_in[55:40] <= ~idx;
        @(posedge clk_in);
        request_valid_in <= 0;
        #1 n = 0;
        while (response_valid_out !== 1'b1 && n++ < 300) @(posedge clk_in) #1;
        v = param_response_output_out;
        check(response_valid_out === 1'b1, "no response");
        check(v[215:32] === 184'h0, "spare bytes");
        check(rsp_index_out === idx, "index echo");
        if (rsn != 0) begin
            check(rsp_code_out === `RSP_ERROR && rsp_length_out === 4 &&
                  v[7:0] === `ERR_MARK && v[31:24] === rsn, "error");
        end else if (op == `OP_WRITE) begin
            ref_mem[idx] = val;
            check(rsp_code_out === `RSP_WRITE && rsp_length_out === 0, "wr");
        end else
            check(rsp_code_out === `RSP_READ && rsp_length_out === 4 &&
                  v[31:0] === (ref_mem.exists(idx) ? ref_mem[idx] : 0), "rd");
    endtask
    task automatic conclude;
        $display("Checks %0d, errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        seed = $urandom(32'hb6cc);
        repeat (12) @(posedge clk_in);
        reset_in <= 0;
        xfer(`OP_WRITE, 16'h0341, 32'h000003e8, 1);
        xfer(`OP_READ, 16'h0341, 0, 0);
        for (int i = 0; i < 24; i++)
            xfer(8'($urandom_range(3)), 16'($urandom_range(7)), $urandom, i % 2);
        for (int r = 1; r < 14; r++)
            xfer(8'(1 + r % 2), {8'hf0, r < 12 ? 8'(r) : 8'(r * 20)}, 0, 0);
        xfer(`OP_READ, 16'he000, 0, 0);
        repeat (2) @(posedge clk_in);
        check(rsp_count == 40, "response count");
        conclude;
    end
endmodule // tb
bind parameter_access_interpreter param_access_assertions
    param_access_assertions_inst (.*);
`default_nettype wire
